// ===== rtl/aic_pkg.sv
// Overview of operation
// RL1 - Single-ended results clamp to 0 below zero scale and 65535 at reference.
// RL2 - Differential code is INT(32767.5 times input over reference plus 32767.5).
// RL3 - Differential code clamps to 65535 at plus reference, 0 at minus reference.
// RL4 - Entering data output immediately drives the sign bit, bit 15.
// RL5 - Next bit appears after each falling clock edge, MSB first.
// RL6 - Exactly 16 result bits, the last finished conversion, no latency.
// RL7 - Answer address 0010100 with select pin low, 1010100 with it high.
// RL8 - START is data falling with clock high, STOP data rising with clock high.
// RL9 - Repeated START keeps the bus busy and acts exactly like START.
// RL10 - Each unit is eight data bits and one acknowledge bit.
// RL11 - Data changes only while clock is low, except START and STOP.
// RL12 - Master sends 7-bit address then direction, 1 read, 0 write.
// RL13 - No acknowledge while converting; acknowledge matching address once done.
// RL14 - Data output ends after 16 result bits or on STOP.
// RL15 - End of a read starts a new conversion automatically.
// RL16 - Write word: two key bits, rate bit, sleep bit, from first rise.
// RL17 - Program bits accepted only when key bits are 1 then 0.
// RL18 - Rate bit defaults to 0 for slow rate, 1 selects fast rate.
// RL19 - Sleep bit 1 powers down reference and converter after next conversion.
// RL20 - Reference and converter power up when an address is acknowledged.
// RL21 - Master should wait 12ms after waking or discard the first result.
// RL22 - Link runs up to 100 kbit/s standard and 400 kbit/s fast.
// RL23 - Conversion lasts 4.8ms slow or 1.2ms fast and cannot be aborted.
// RL24 - Reset restores defaults and then starts a conversion.
// RL25 - STOP after an acknowledged read address discards result, starts conversion.
// RL26 - After conversion the device naps until an address is acknowledged.
// RL27 - Program word wire order: key high, key low, rate, sleep.
// RL28 - Wrong key pattern leaves rate and sleep settings unchanged.
`default_nettype none
package aic_pkg;
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam logic [1:0] REG_RESULT = 2'h2;
    localparam int CTRL_DIFF_POS = 0;
    localparam logic CTRL_DIFF_RESET = 1'h0;
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_RATE_POS = 1;
    localparam int STAT_SLEEP_POS = 2;
    localparam int STAT_REF_POS = 3;
    localparam int STAT_CONV_POS = 4;
    localparam logic [6:0] ADDR_SEL_LOW = 7'h14;
    localparam logic [6:0] ADDR_SEL_HIGH = 7'h54;
    localparam int PROG_KEY_HIGH_POS = 3;
    localparam int PROG_KEY_LOW_POS = 2;
    localparam int PROG_RATE_POS = 1;
    localparam int PROG_SLEEP_POS = 0;
    localparam logic PROG_RATE_RESET = 1'h0;
    localparam logic PROG_SLEEP_RESET = 1'h0;
    localparam int RESULT_BITS = 16;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_SLOW_TIME_US = 4800;
    localparam int CONV_FAST_TIME_US = 1200;
    localparam int CONV_SLOW_CYC = CONV_SLOW_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int CONV_FAST_CYC = CONV_FAST_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam logic signed [18:0] CODE_MAX = 19'sh0ffff;

    typedef struct packed {
        logic rate_select;
        logic reference_sleep;
    } aic_prog_t;
endpackage
`default_nettype wire

// ===== rtl/aic_converter.sv
`timescale 1ns/1ps
`default_nettype none
module aic_converter #(
    parameter int SLOW_CYC = aic_pkg::CONV_SLOW_CYC,
    parameter int FAST_CYC = aic_pkg::CONV_FAST_CYC
) (
    input wire logic sys_clk_i, // System clock
    input wire logic reset_n_i, // Async reset
    input wire logic ce_i, // Clock enable
    input wire logic start_i, // Start request
    input wire logic rate_fast_i, // Fast rate
    input wire logic diff_mode_i, // Differential variant
    input wire logic signed [17:0] sample_i, // Scaled input
    output logic busy_o, // Converting
    output logic done_o, // Finish pulse
    output logic [15:0] result_o // Last result
);
    localparam int CW = $clog2(SLOW_CYC + 1);

    // Single-ended: sample is the code; differential: sample is 65535*x/ref
    function automatic logic [15:0] code_of(input logic diff, input logic signed [17:0] s);
        logic signed [18:0] v;
        v = diff ? ((19'(s) + aic_pkg::CODE_MAX) >>> 1) : 19'(s); // [RL2]
        if (v < 0)
            code_of = 16'h0000; // [RL1] [RL3]
        else if (v > aic_pkg::CODE_MAX)
            code_of = 16'hffff; // [RL1] [RL3]
        else
            code_of = v[15:0];
    endfunction

    logic [CW-1:0] cnt;
    wire [CW-1:0] load_val = rate_fast_i ? CW'(FAST_CYC - 1) : CW'(SLOW_CYC - 1);
    wire finish = busy_o && cnt == '0;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            cnt <= '0;
            result_o <= 16'h0000;
        end else if (ce_i) begin
            done_o <= finish;
            if (!busy_o && start_i) begin // [RL23]
                busy_o <= 1'b1;
                cnt <= load_val;
            end else if (finish) begin
                busy_o <= 1'b0;
                result_o <= code_of(diff_mode_i, sample_i); // [RL6]
            end else if (busy_o) begin
                cnt <= cnt - 1'b1;
            end
        end
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    conv_len_a: assert property ($rose(busy_o) |-> busy_o [*8]) // [RL23]
        else $error("conversion ended too early");
    clamp_low_a: assert property (done_o && $past(ce_i) && !$past(diff_mode_i) // [RL1]
        && $past(sample_i) < 0 |-> result_o == 16'h0000)
        else $error("single-ended underrange not zero");
endmodule // aic_converter
`default_nettype wire

// ===== rtl/aic_port.sv
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module aic_port #(
    parameter int SLOW_CYC = aic_pkg::CONV_SLOW_CYC,
    parameter int FAST_CYC = aic_pkg::CONV_FAST_CYC
) (
    input wire logic sys_clk_i, // System clock, 20 MHz
    input wire logic reset_n_i, // Async reset, active low
    input wire logic ce_i, // Clock enable
    input wire logic scl_i, // Serial clock pin
    input wire logic sda_i, // Serial data pin level
    output logic sda_o, // Serial data drive value
    output logic sda_oe_o, // Serial data pull-down enable
    input wire logic address_select_pin_i, // Address select pin
    input wire logic signed [17:0] sample_i, // Scaled analog input
    input wire logic [1:0] reg_addr_i, // Register index
    input wire logic [7:0] reg_wdata_i, // Register write data
    input wire logic reg_wr_i, // Register write strobe
    input wire logic reg_rd_i, // Register read strobe
    output logic [15:0] reg_rdata_o, // Register read data
    output logic ref_power_o, // Reference powered
    output logic conv_power_o // Converter powered
);
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_AACK = 7'h04,
        ST_READ = 7'h08,
        ST_MACK = 7'h10,
        ST_WRITE = 7'h20,
        ST_WACK = 7'h40
    } aic_state_t;

    // Pin synchronisers: scl, sda, address select
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic scl_d;
    logic sda_d;
    wire [2:0] pin_raw = {address_select_pin_i, sda_i, scl_i};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    pin_meta[g] <= 1'b1;
                    pin_sync[g] <= 1'b1;
                end else if (ce_i) begin
                    pin_meta[g] <= pin_raw[g];
                    pin_sync[g] <= pin_meta[g];
                end
            end
        end
    endgenerate

    // 20 MHz sampling gives 50 samples per bit at 400 kbit/s
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin // [RL22]
        if (!reset_n_i) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else if (ce_i) begin
            scl_d <= pin_sync[0];
            sda_d <= pin_sync[1];
        end
    end

    wire scl_s = pin_sync[0];
    wire sda_s = pin_sync[1];
    wire a0_s = pin_sync[2];
    wire scl_rise = scl_s && !scl_d;
    wire scl_fall = !scl_s && scl_d;
    wire start_w = scl_s && scl_d && sda_d && !sda_s; // [RL8] [RL9]
    wire stop_w = scl_s && scl_d && !sda_d && sda_s; // [RL8]

    // Slave state
    aic_state_t state;
    aic_state_t next_state;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] addr_sr;
    logic [3:0] wr_sr;
    logic [15:0] out_sr;
    logic [15:0] next_out_sr;
    logic next_oe;
    logic read_end_w;

    // Conversion and settings
    aic_pkg::aic_prog_t prog;
    logic ctrl_diff;
    logic boot_pending;
    logic conv_busy;
    logic conv_done;
    logic [15:0] conv_result;

    wire [6:0] my_addr = a0_s ? aic_pkg::ADDR_SEL_HIGH : aic_pkg::ADDR_SEL_LOW; // [RL7]
    wire conv_start = boot_pending || read_end_w; // [RL24] [RL15]
    wire in_convert = conv_busy || conv_start;
    wire addr_hit = addr_sr[7:1] == my_addr; // [RL7]
    wire addr_ack = addr_hit && !in_convert; // [RL13]
    wire rw_read = addr_sr[0]; // [RL12]
    wire [3:0] prog_word = {wr_sr[2:0], sda_s}; // [RL27]
    wire prog_load = state == ST_WRITE && scl_rise && bit_cnt == 4'h3; // [RL16]
    wire key_ok = prog_word[aic_pkg::PROG_KEY_HIGH_POS]
        && !prog_word[aic_pkg::PROG_KEY_LOW_POS]; // [RL17]
    wire acked = state == ST_ADDR && scl_fall && bit_cnt == 4'h8 && addr_ack;

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_out_sr = out_sr;
        next_oe = sda_oe_o;
        read_end_w = 1'b0;
        if (start_w) begin // [RL9]
            next_state = ST_ADDR;
            next_bit_cnt = 4'h0;
            next_oe = 1'b0;
        end else if (stop_w) begin // [RL14] [RL25]
            read_end_w = state == ST_READ || state == ST_MACK;
            next_state = ST_IDLE;
            next_oe = 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    next_oe = 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin // [RL10]
                        next_state = addr_ack ? ST_AACK : ST_IDLE; // [RL13]
                        next_oe = addr_ack; // [RL13]
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin // [RL11]
                        next_bit_cnt = 4'h0;
                        if (rw_read) begin
                            next_state = ST_READ;
                            next_out_sr = {conv_result[14:0], 1'b0}; // [RL6]
                            next_oe = !conv_result[15]; // [RL4]
                        end else begin
                            next_state = ST_WRITE;
                            next_oe = 1'b0;
                        end
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin // [RL5] [RL11]
                        if (bit_cnt == 4'hf) begin // [RL14]
                            read_end_w = 1'b1; // [RL15]
                            next_state = ST_IDLE;
                            next_oe = 1'b0;
                        end else if (bit_cnt == 4'h7) begin // [RL10]
                            next_state = ST_MACK;
                            next_bit_cnt = 4'h8;
                            next_oe = 1'b0;
                        end else begin
                            next_bit_cnt = bit_cnt + 4'h1;
                            next_oe = !out_sr[15]; // [RL5]
                            next_out_sr = {out_sr[14:0], 1'b0};
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_fall) begin
                        next_state = ST_READ;
                        next_oe = !out_sr[15]; // [RL5]
                        next_out_sr = {out_sr[14:0], 1'b0};
                    end
                end
                ST_WRITE: begin
                    if (scl_rise) begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin // [RL10]
                        next_state = ST_WACK;
                        next_oe = 1'b1;
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        next_state = ST_IDLE;
                        next_oe = 1'b0;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                    next_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            out_sr <= 16'h0000;
            sda_oe_o <= 1'b0;
            sda_o <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            out_sr <= next_out_sr;
            sda_oe_o <= next_oe;
            sda_o <= 1'b0;
        end
    end

    // Incoming bits are taken on the rising clock edge
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_sr <= 8'h00;
            wr_sr <= 4'h0;
        end else if (ce_i && scl_rise) begin
            if (state == ST_ADDR)
                addr_sr <= {addr_sr[6:0], sda_s};
            if (state == ST_WRITE)
                wr_sr <= {wr_sr[2:0], sda_s}; // [RL16]
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prog.rate_select <= aic_pkg::PROG_RATE_RESET; // [RL24]
            prog.reference_sleep <= aic_pkg::PROG_SLEEP_RESET;
        end else if (ce_i && prog_load && key_ok) begin // [RL17] [RL28]
            prog.rate_select <= prog_word[aic_pkg::PROG_RATE_POS]; // [RL18]
            prog.reference_sleep <= prog_word[aic_pkg::PROG_SLEEP_POS]; // [RL19]
        end
    end

    // Power flags: nap drops the converter, sleep drops the reference too
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            boot_pending <= 1'b1;
            ref_power_o <= 1'b1;
            conv_power_o <= 1'b0;
        end else if (ce_i) begin
            boot_pending <= 1'b0; // [RL24]
            if (acked) begin // [RL20]
                ref_power_o <= 1'b1;
                conv_power_o <= 1'b1;
            end else if (conv_done) begin // [RL26]
                conv_power_o <= 1'b0;
                if (prog.reference_sleep)
                    ref_power_o <= 1'b0; // [RL19]
            end else if (conv_start) begin
                conv_power_o <= 1'b1;
            end
        end
    end

    aic_converter #(
        .SLOW_CYC(SLOW_CYC),
        .FAST_CYC(FAST_CYC)
    ) u_conv (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .start_i(conv_start),
        .rate_fast_i(prog.rate_select), // [RL18]
        .diff_mode_i(ctrl_diff),
        .sample_i(sample_i),
        .busy_o(conv_busy),
        .done_o(conv_done),
        .result_o(conv_result)
    );

    // Register port
    wire [15:0] status_word = {11'h000, conv_power_o, ref_power_o,
        prog.reference_sleep, prog.rate_select, conv_busy};
    wire [15:0] read_mux = reg_addr_i == aic_pkg::REG_CTRL ? {15'h0000, ctrl_diff} :
        reg_addr_i == aic_pkg::REG_STATUS ? status_word :
        reg_addr_i == aic_pkg::REG_RESULT ? conv_result : 16'h0000;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_diff <= aic_pkg::CTRL_DIFF_RESET;
            reg_rdata_o <= 16'h0000;
        end else if (ce_i) begin
            reg_rdata_o <= reg_rd_i ? read_mux : 16'h0000;
            if (reg_wr_i && reg_addr_i == aic_pkg::REG_CTRL)
                ctrl_diff <= reg_wdata_i[aic_pkg::CTRL_DIFF_POS];
        end
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    nack_busy_a: assert property (ce_i && state == ST_ADDR && scl_fall && !start_w // [RL13]
        && !stop_w && bit_cnt == 4'h8 && in_convert |=> state == ST_IDLE && !sda_oe_o)
        else $error("address answered during conversion");
    ack_drive_a: assert property (state == ST_AACK || state == ST_WACK |-> sda_oe_o) // [RL13]
        else $error("acknowledge not driven");
    sign_first_a: assert property (ce_i && state == ST_AACK && scl_fall && rw_read // [RL4]
        && !start_w && !stop_w |=> sda_oe_o == !conv_result[15])
        else $error("sign bit not presented first");
    read_conv_a: assert property (ce_i && read_end_w |=> ce_i |=> conv_busy) // [RL15]
        else $error("read end did not start conversion");
    stop_idle_a: assert property (ce_i && stop_w && !start_w // [RL14]
        |=> state == ST_IDLE && !sda_oe_o)
        else $error("stop did not end transfer");
    start_addr_a: assert property (ce_i && start_w |=> state == ST_ADDR && bit_cnt == 4'h0) // [RL9]
        else $error("start not restarting address phase");
    key_hold_a: assert property (ce_i && prog_load && !key_ok |=> $stable(prog)) // [RL28]
        else $error("settings changed without key");
    sleep_ref_a: assert property (ce_i && conv_done && !acked && prog.reference_sleep // [RL19]
        |=> !ref_power_o)
        else $error("reference kept powered in sleep");
    wake_ref_a: assert property ($rose(state == ST_AACK) |-> ref_power_o && conv_power_o) // [RL20]
        else $error("acknowledge did not wake");
    fall_only_a: assert property ($changed(sda_oe_o) && !$past(start_w) && !$past(stop_w) // [RL11]
        && $past(state) != ST_ADDR |-> !$past(scl_s))
        else $error("data changed with clock high");
endmodule // aic_port
`default_nettype wire

// ===== verification/aic_master.sv
`timescale 1ns/1ps
`default_nettype none
module aic_master (
    input wire logic sys_clk_i, // Bench clock
    input wire logic sda_i, // Resolved data wire
    output logic scl_o, // Serial clock drive
    output logic sda_oe_o // High pulls the data wire low
);
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // One SCL period of 8 cycles; the read is taken late in the high phase
    task automatic put_bit(input logic b, output logic got);
        tick(2);
        sda_oe_o <= !b;
        tick(2);
        scl_o <= 1'b1;
        tick(3);
        @(negedge sys_clk_i);
        got = sda_i;
        @(posedge sys_clk_i);
        scl_o <= 1'b0;
    endtask

    // Works from idle and as a repeated start with SCL low
    task automatic start();
        tick(2);
        sda_oe_o <= 1'b0;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_oe_o <= 1'b1;
        tick(4);
        scl_o <= 1'b0;
    endtask

    task automatic stop();
        tick(2);
        sda_oe_o <= 1'b1;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_oe_o <= 1'b0;
        tick(4);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], g);
        end
        put_bit(1'b1, g);
        ack = !g;
    endtask

    task automatic get_byte(input logic last, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, g);
            d[i] = g;
        end
        put_bit(last, g);
    endtask
endmodule // aic_master
`default_nettype wire

// ===== verification/aic_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module aic_port_test;
    localparam int SLOW = 200;
    localparam int FAST = 100;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic addr_sel = 1'b0;
    logic signed [17:0] sample = '0;
    logic [1:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ce = 1'b1;
    logic [15:0] reg_rdata;
    logic scl, m_pull, dut_sda, dut_oe, ref_pw, conv_pw;
    logic exp_rate = 1'b0;
    logic exp_sleep = 1'b0;
    logic [15:0] exp_code;
    int error_cnt = 0;
    int n_tests = 0;
    // Pull-up wire: low when any party pulls
    wire sda_wire = !(m_pull || (dut_oe && !dut_sda));

    always #25 sys_clk_i = !sys_clk_i;

    aic_port #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) DUT (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .ce_i(ce), .scl_i(scl),
        .sda_i(sda_wire), .sda_o(dut_sda), .sda_oe_o(dut_oe), .address_select_pin_i(addr_sel),
        .sample_i(sample), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .ref_power_o(ref_pw), .conv_power_o(conv_pw));

    aic_master M (.sys_clk_i(sys_clk_i), .sda_i(sda_wire), .scl_o(scl), .sda_oe_o(m_pull));

    function automatic logic [15:0] model(input int v, input logic diff);
        int c;
        c = diff ? ((v + 65535) >>> 1) : v;
        if (c < 0) c = 0;
        if (c > 65535) c = 65535;
        return c[15:0];
    endfunction

    function automatic logic [6:0] addr_of(input logic sel);
        return sel ? aic_pkg::ADDR_SEL_HIGH : aic_pkg::ADDR_SEL_LOW;
    endfunction

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [1:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd <= 1'b0;
        @(negedge sys_clk_i);
        d = reg_rdata;
        @(posedge sys_clk_i);
    endtask

    task automatic check_prog(input logic busy);
        logic [15:0] s;
        reg_read(aic_pkg::REG_STATUS, s);
        check("busy", {15'h0, busy}, {15'h0, s[aic_pkg::STAT_BUSY_POS]});
        check("rate_select", {15'h0, exp_rate}, {15'h0, s[aic_pkg::STAT_RATE_POS]});
        check("reference_sleep", {15'h0, exp_sleep}, {15'h0, s[aic_pkg::STAT_SLEEP_POS]});
    endtask

    // Polls the busy flag; returns cycles elapsed since t0
    task automatic wait_idle(input realtime t0, output int cyc);
        logic [15:0] s;
        s = 16'h1;
        for (int i = 0; i < 400 && s[aic_pkg::STAT_BUSY_POS] !== 1'b0; i++) begin
            reg_read(aic_pkg::REG_STATUS, s);
        end
        cyc = int'(($realtime - t0) / 50.0);
    endtask

    task automatic read_result(input logic [6:0] a, input logic take, output logic ack,
                               output logic pw, output logic [15:0] d);
        logic [7:0] hi, lo;
        M.start();
        M.send_byte({a, 1'b1}, ack);
        pw = ref_pw;
        d = '0;
        if (ack && take) begin
            M.get_byte(1'b0, hi);
            M.get_byte(1'b1, lo);
            d = {hi, lo};
        end
    endtask

    task automatic prog(input logic [3:0] w);
        logic ack;
        M.start();
        M.send_byte({addr_of(addr_sel), 1'b0}, ack);
        check("write_ack", 16'h1, {15'h0, ack});
        M.send_byte({w, 4'h0}, ack);
        check("data_ack", 16'h1, {15'h0, ack});
        M.stop();
        if (w[3:2] == 2'b10) begin
            exp_rate = w[1];
            exp_sleep = w[0];
        end
        check_prog(1'b0);
    endtask

    initial begin
        logic ack, pw;
        logic [15:0] d;
        logic [3:0] keys [5];
        int cyc, v;
        realtime t0;
        keys = '{4'he, 4'h5, 4'hd, 4'h1, 4'hb};
        void'($urandom(8));
        v = int'($urandom_range(262143)) - 131072;
        sample <= v[17:0];
        exp_code = model(v, 1'b0);
        repeat (3) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        @(posedge sys_clk_i);
        t0 = $realtime;
        reg_write(aic_pkg::REG_STATUS, 8'hff);
        check_prog(1'b1);
        check("ref_power", 16'h1, {15'h0, ref_pw});
        reg_read(2'h3, d);
        check("unmapped", 16'h0, d);
        read_result(addr_of(1'b0), 1'b1, ack, pw, d);
        check("boot_ack", 16'h0, {15'h0, ack});
        M.stop();
        wait_idle(t0, cyc);
        check("boot_time", 16'h1, {15'h0, cyc >= SLOW - 10 && cyc <= SLOW + 10});
        check("nap_conv", 16'h0, {15'h0, conv_pw});
        check("nap_ref", 16'h1, {15'h0, ref_pw});
        for (int k = 0; k < 8; k++) begin
            addr_sel <= k[0];
            @(posedge sys_clk_i);
            read_result(addr_of(!k[0]), 1'b1, ack, pw, d);
            check("foreign_ack", 16'h0, {15'h0, ack});
            read_result(addr_of(k[0]), 1'b1, ack, pw, d);
            check("addr_ack", 16'h1, {15'h0, ack});
            check("result", exp_code, d);
            M.stop();
            t0 = $realtime;
            v = (k == 7) ? 60000 : int'($urandom_range(262143)) - 131072;
            sample <= v[17:0];
            reg_write(aic_pkg::REG_CTRL, {7'h0, k[1]});
            exp_code = model(v, k[1]);
            read_result(addr_of(k[0]), 1'b1, ack, pw, d);
            check("busy_ack", 16'h0, {15'h0, ack});
            M.stop();
            wait_idle(t0, cyc);
            check("slow_time", 16'h1, {15'h0, cyc >= SLOW - 30 && cyc <= SLOW + 8});
            reg_read(aic_pkg::REG_RESULT, d);
            check("result_reg", exp_code, d);
            reg_read(aic_pkg::REG_CTRL, d);
            check("diff_reg", {15'h0, k[1]}, d);
        end
        // Held code has its sign bit set, so the line is free for the stop
        read_result(addr_of(1'b1), 1'b0, ack, pw, d);
        check("abort_ack", 16'h1, {15'h0, ack});
        M.stop();
        t0 = $realtime;
        v = int'($urandom_range(65535));
        sample <= v[17:0];
        reg_write(aic_pkg::REG_CTRL, 8'h0);
        exp_code = model(v, 1'b0);
        // Freezing the block for 40 cycles stretches the conversion by as much
        ce <= 1'b0;
        repeat (40) @(posedge sys_clk_i);
        ce <= 1'b1;
        wait_idle(t0, cyc);
        check("abort_time", 16'h1, {15'h0, cyc >= SLOW + 10 && cyc <= SLOW + 48});
        foreach (keys[i]) begin
            prog(keys[i]);
        end
        read_result(addr_of(1'b1), 1'b1, ack, pw, d);
        check("result", exp_code, d);
        M.stop();
        t0 = $realtime;
        v = int'($urandom_range(262143)) - 131072;
        sample <= v[17:0];
        exp_code = model(v, 1'b0);
        wait_idle(t0, cyc);
        check("fast_time", 16'h1, {15'h0, cyc >= FAST - 30 && cyc <= FAST + 8});
        check("sleep_ref", 16'h0, {15'h0, ref_pw});
        check("sleep_conv", 16'h0, {15'h0, conv_pw});
        read_result(addr_of(1'b1), 1'b1, ack, pw, d);
        check("wake_ref", 16'h1, {15'h0, pw});
        check("result", exp_code, d);
        M.stop();
        t0 = $realtime;
        // First result after the reference wakes is left unread
        wait_idle(t0, cyc);
        prog(4'h8);
        conclude();
    end

    // Budget well above the expected run length
    initial begin
        #(2_000_000);
        error_cnt++;
        conclude();
    end
endmodule // aic_port_test
`default_nettype wire
